// ---- hdl/ext_irq_pkg.sv ----
// constants, types and register layout for external interrupt conditioning
// assumes a single 100 MHz clock that is also the high-frequency clock
// Functional notes
// - software trap fires at once, top priority
// - trap opcode acts as no-op during NMI
// - void single-chip fetch returns FFH, address error
// - fetch from RAM, buffer, register area traps
// - five inputs, each through its noise filter
// - shared pin port when select 0, irq 1
// - select 0 blocks pin A latch setting
// - A and E falling only, 2/6 filter
// - B filter 15/48 or 63/192 by bit
// - C and D filter 7/24
// - clean edge latched within 49, 193, 25
// - D select: rise, fall, both, high level
// - B and C select: 0 rise, 1 fall
// - B filter time change within 64 cycles
// - D level needs rising edge after reset
// - port output changes may fake requests
// - maskable requests wait for master enable
package ext_irq_pkg;

    localparam int HIGH_FREQ_CLOCK_HZ = 100_000_000;

    // register offsets
    localparam logic [7:0] EXT_INT_CONTROL_ADDR = 8'h37;
    localparam logic [7:0] IRQ_PENDING_ADDR     = 8'h40;
    localparam logic [7:0] IRQ_CLEAR_ADDR       = 8'h41;
    localparam logic [7:0] IRQ_ENABLE_ADDR      = 8'h42;
    localparam logic [7:0] EXT_INT_CONTROL_RST  = 8'h00;
    localparam logic [7:0] CONTROL_RW_MASK      = 8'hF6;

    // field positions of ext_int_control
    localparam int FILT_B_TIME_BIT = 7;
    localparam int PIN_A_FUNC_BIT  = 6;
    localparam int EDGE_D_LSB      = 4;
    localparam int EDGE_C_BIT      = 2;
    localparam int EDGE_B_BIT      = 1;

    typedef struct packed {
        logic       filt_b_time_sel;
        logic       pin_a_func_sel;
        logic [1:0] edge_d_sel;
        logic       rsvd3;
        logic       edge_c_sel;
        logic       edge_b_sel;
        logic       rsvd0;
    } ctrl_type;

    typedef enum logic [1:0] {
        TRIG_RISE  = 2'b00,
        TRIG_FALL  = 2'b01,
        TRIG_BOTH  = 2'b10,
        TRIG_LEVEL = 2'b11
    } trig_type;

    // filter thresholds in stable high_freq_clock cycles
    localparam int          FILT_CNT_W   = 8;
    localparam logic [7:0]  FILT_THR_AE  = 8'h03;
    localparam logic [7:0]  FILT_THR_BS  = 8'h28;
    localparam logic [7:0]  FILT_THR_BL  = 8'hA0;
    localparam logic [7:0]  FILT_THR_CD  = 8'h12;

    // fixed areas of the address space
    localparam logic [15:0] SPECIAL_REG_LO = 16'h0000;
    localparam logic [15:0] SPECIAL_REG_HI = 16'h003F;
    localparam logic [15:0] EXT_BUF_LO     = 16'h1F70;
    localparam logic [15:0] EXT_BUF_HI     = 16'h1F7F;
    localparam logic [15:0] DATA_BUF_LO    = 16'h1F80;
    localparam logic [15:0] DATA_BUF_HI    = 16'h1FFF;

    localparam logic [7:0]  SOFT_TRAP_OPCODE = 8'hFF;
    localparam logic [7:0]  VOID_FETCH_BYTE  = 8'hFF;

    // accept identifiers, 0 is the software trap
    localparam logic [2:0]  ID_SOFT_TRAP = 3'h0;
    localparam logic [2:0]  ID_NONE      = 3'h7;

endpackage : ext_irq_pkg

// ---- hdl/noise_filter.sv ----
// digital noise filter for one external interrupt pin
// assumes the pin is asynchronous; threshold may change at any time
`timescale 1ns/100ps
`default_nettype none
module noise_filter
    import ext_irq_pkg::*;
#(
    parameter int CNT_W = FILT_CNT_W
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             pin,
    input  wire logic [CNT_W-1:0] thr,
    output logic                  level,
    output logic                  settled
);

    logic             sync1;
    logic             sync2;
    logic             sync_prev;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    wire             stable  = sync2 == sync_prev;
    wire             differs = ~settled | (sync2 != level);
    wire [CNT_W-1:0] cnt_inc = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    // >= so a shorter threshold written mid-count takes hold at once
    wire             done    = differs & stable & (cnt_inc >= thr);

    always_comb
    begin
        next_cnt = cnt_inc;
        if (!stable || !differs || done)
            next_cnt = '0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1     <= 1'b0;
            sync2     <= 1'b0;
            sync_prev <= 1'b0;
            cnt       <= '0;
            level     <= 1'b0;
            settled   <= 1'b0;
        end
        else
        begin
            sync1     <= pin;
            sync2     <= sync1;
            sync_prev <= sync2;
            cnt       <= next_cnt;
            if (done)
            begin
                level   <= sync2;
                settled <= 1'b1;
            end
        end
    end

endmodule : noise_filter
`default_nettype wire

// ---- hdl/ext_irq_conditioning.sv ----
// external interrupt conditioning, software trap and fetch trapping
// assumes register port strobes are one cycle and never overlap;
// the cpu core reports fetches and executed opcodes by strobes
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module ext_irq_conditioning
    import ext_irq_pkg::*;
#(
    parameter logic [15:0] ROM_LO = 16'hC000,
    parameter logic [15:0] ROM_HI = 16'hFFFF,
    parameter logic [15:0] RAM_LO = 16'h0040,
    parameter logic [15:0] RAM_HI = 16'h083F
)
(
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    input  wire logic        EXT_IRQ_A,
    input  wire logic        EXT_IRQ_B,
    input  wire logic        EXT_IRQ_C,
    input  wire logic        EXT_IRQ_D,
    input  wire logic        EXT_IRQ_E,
    input  wire logic        PORT_BIT_DATA,
    input  wire logic        PORT_BIT_DIR,
    output logic             SHARED_PIN_O,
    output logic             SHARED_PIN_OE,
    output logic             SHARED_PORT_BIT_IN,
    input  wire logic        MASTER_IRQ_ENABLE,
    input  wire logic        NMI_ACTIVE,
    input  wire logic        EXEC_STROBE,
    input  wire logic [7:0]  EXEC_OPCODE,
    output logic             SOFT_TRAP_IRQ,
    output logic             EXEC_AS_NOP,
    output logic             ADDR_ERROR,
    input  wire logic        SINGLE_CHIP,
    input  wire logic        FETCH_STROBE,
    input  wire logic [15:0] FETCH_ADDR,
    input  wire logic [7:0]  FETCH_DATA_IN,
    output logic      [7:0]  FETCH_DATA,
    output logic             ADDR_TRAP_RESET,
    output logic      [4:0]  IRQ_PENDING,
    output logic             IRQ_ACCEPT_VALID,
    output logic      [2:0]  IRQ_ACCEPT_ID
);

    function automatic logic in_range(input logic [15:0] a,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // lowest index wins; index 0 is pin A
    function automatic logic [2:0] first_set(input logic [4:0] v);
        first_set = ID_NONE;
        for (int i = 4; i >= 0; i--)
            if (v[i])
                first_set = 3'(i + 1);
    endfunction : first_set

    function automatic logic edge_hit(input logic rise,
                                      input logic fall,
                                      input logic sel_fall);
        edge_hit = sel_fall ? fall : rise;
    endfunction : edge_hit

    ctrl_type    ctrl;
    logic [4:0]  enable;
    logic [4:0]  pending;
    logic [4:0]  level_prev;
    logic [4:0]  settled_prev;
    logic        d_armed;
    logic        void_fetch;
    logic [7:0]  rdata;

    logic [4:0]  level;
    logic [4:0]  settled;
    logic [4:0]  pins;
    logic [FILT_CNT_W-1:0] thr [5];

    assign pins = {EXT_IRQ_E, EXT_IRQ_D, EXT_IRQ_C, EXT_IRQ_B, EXT_IRQ_A};

    assign thr[0] = FILT_THR_AE;
    assign thr[4] = FILT_THR_AE;
    assign thr[1] = ctrl.filt_b_time_sel ? FILT_THR_BS : FILT_THR_BL;
    assign thr[2] = FILT_THR_CD;
    assign thr[3] = FILT_THR_CD;

    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : gen_filt
            noise_filter #(
                .CNT_W   (FILT_CNT_W)
            ) u_filt (
                .clk     (MCLK),
                .rst_n   (RST_N),
                .pin     (pins[g]),
                .thr     (thr[g]),
                .level   (level[g]),
                .settled (settled[g])
            );
        end
    endgenerate

    // edges only count once both samples were filtered values
    wire [4:0] valid_pair = settled & settled_prev;
    wire [4:0] rise       = valid_pair & level & ~level_prev;
    wire [4:0] fall       = valid_pair & ~level & level_prev;
    wire [1:0] d_mode     = ctrl.edge_d_sel;

    wire req_a = fall[0] & ctrl.pin_a_func_sel;
    wire req_b = edge_hit(rise[1], fall[1], ctrl.edge_b_sel);
    wire req_c = edge_hit(rise[2], fall[2], ctrl.edge_c_sel);
    wire req_e = fall[4];

    logic req_d;
    always_comb
    begin
        unique case (trig_type'(d_mode))
            TRIG_RISE:  req_d = rise[3];
            TRIG_FALL:  req_d = fall[3];
            TRIG_BOTH:  req_d = rise[3] | fall[3];
            TRIG_LEVEL: req_d = level[3] & d_armed & settled[3];
        endcase
    end

    wire [4:0] req = {req_e, req_d, req_c, req_b, req_a};

    // register port decode
    wire sel_ctrl = REG_ADDR == EXT_INT_CONTROL_ADDR;
    wire sel_pend = REG_ADDR == IRQ_PENDING_ADDR;
    wire sel_clr  = REG_ADDR == IRQ_CLEAR_ADDR;
    wire sel_en   = REG_ADDR == IRQ_ENABLE_ADDR;
    wire wr_ctrl  = REG_WR & sel_ctrl;
    wire wr_clr   = REG_WR & sel_clr;
    wire wr_en    = REG_WR & sel_en;

    wire [4:0] clr_mask = wr_clr ? REG_WDATA[4:0] : 5'h00;
    // set wins over a clear in the same cycle
    wire [4:0] next_pending = req | (pending & ~clr_mask);

    // reserved control bits read as zero
    wire [7:0] ctrl_rd = ctrl & CONTROL_RW_MASK;
    wire [7:0] next_rdata =
        sel_ctrl ? ctrl_rd :
        sel_pend ? {3'h0, pending} :
        sel_clr  ? {3'h0, level} :
        sel_en   ? {3'h0, enable} : 8'h00;

    wire [7:0] ctrl_wr = REG_WDATA & CONTROL_RW_MASK;

    assign SHARED_PIN_O  = PORT_BIT_DATA;
    assign SHARED_PIN_OE = PORT_BIT_DIR & ~ctrl.pin_a_func_sel;

    wire [4:0] maskable = pending & enable & {5{MASTER_IRQ_ENABLE}};

    wire trap_op   = EXEC_STROBE & (EXEC_OPCODE == SOFT_TRAP_OPCODE);
    wire trap_fire = trap_op & ~NMI_ACTIVE;

    wire known =
        in_range(FETCH_ADDR, ROM_LO, ROM_HI) |
        in_range(FETCH_ADDR, RAM_LO, RAM_HI) |
        in_range(FETCH_ADDR, SPECIAL_REG_LO, SPECIAL_REG_HI) |
        in_range(FETCH_ADDR, EXT_BUF_LO, EXT_BUF_HI) |
        in_range(FETCH_ADDR, DATA_BUF_LO, DATA_BUF_HI);
    wire fetch_void = FETCH_STROBE & SINGLE_CHIP & ~known;

    wire fetch_trap = FETCH_STROBE & (
        in_range(FETCH_ADDR, RAM_LO, RAM_HI) |
        in_range(FETCH_ADDR, DATA_BUF_LO, DATA_BUF_HI) |
        in_range(FETCH_ADDR, SPECIAL_REG_LO, SPECIAL_REG_HI));

    wire [7:0] next_fetch =
        fetch_void ? VOID_FETCH_BYTE : FETCH_DATA_IN;

    // remembers that the byte under execution came from nowhere
    wire next_void = FETCH_STROBE ? fetch_void : void_fetch;

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            ctrl <= ctrl_type'(EXT_INT_CONTROL_RST);
            enable <= 5'h00;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= ctrl_type'(ctrl_wr);
            if (wr_en)
                enable <= REG_WDATA[4:0];
        end
    end

    // latches hold until software writes them off at the clear address
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            pending <= 5'h00;
        else
            pending <= next_pending;
    end

    // captured only on a read, so a late look still sees the last answer
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            rdata <= 8'h00;
        else if (REG_RD)
            rdata <= next_rdata;
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            level_prev <= 5'h00;
            settled_prev <= 5'h00;
            d_armed <= 1'b0;
        end
        else
        begin
            level_prev <= level;
            settled_prev <= settled;
            // only a reset disarms, so later falls keep level mode live
            if (rise[3])
                d_armed <= 1'b1;
        end
    end

    // trap and its no-op twin are exclusive: NMI_ACTIVE picks one
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            SOFT_TRAP_IRQ <= 1'b0;
            EXEC_AS_NOP <= 1'b0;
            ADDR_ERROR <= 1'b0;
        end
        else
        begin
            SOFT_TRAP_IRQ <= trap_fire;
            EXEC_AS_NOP <= trap_op & NMI_ACTIVE;
            ADDR_ERROR <= trap_fire & void_fetch;
        end
    end

    // fetch data holds between strobes for a core that reads it late
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            void_fetch <= 1'b0;
            FETCH_DATA <= 8'h00;
            ADDR_TRAP_RESET <= 1'b0;
        end
        else
        begin
            void_fetch <= next_void;
            if (FETCH_STROBE)
                FETCH_DATA <= next_fetch;
            ADDR_TRAP_RESET <= fetch_trap;
        end
    end

    // the port read path stays live whichever function the pin has
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            SHARED_PORT_BIT_IN <= 1'b0;
        else
            SHARED_PORT_BIT_IN <= EXT_IRQ_A;
    end

    assign REG_RDATA = rdata;
    assign IRQ_PENDING = pending;

    assign IRQ_ACCEPT_VALID = SOFT_TRAP_IRQ | (|maskable);
    assign IRQ_ACCEPT_ID = SOFT_TRAP_IRQ ? ID_SOFT_TRAP :
                           first_set(maskable);

endmodule : ext_irq_conditioning
`default_nettype wire

// ---- test/ext_irq_props.sv ----
// checker on the ports of the conditioning block
// assumes the block's default memory ranges
`timescale 1ns/100ps
`default_nettype none
module ext_irq_props
    import ext_irq_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        RST_N,
    input wire logic        EXT_IRQ_E,
    input wire logic        PORT_BIT_DIR,
    input wire logic        SHARED_PIN_OE,
    input wire logic        MASTER_IRQ_ENABLE,
    input wire logic        NMI_ACTIVE,
    input wire logic        EXEC_STROBE,
    input wire logic [7:0]  EXEC_OPCODE,
    input wire logic        SOFT_TRAP_IRQ,
    input wire logic        EXEC_AS_NOP,
    input wire logic        SINGLE_CHIP,
    input wire logic        FETCH_STROBE,
    input wire logic [15:0] FETCH_ADDR,
    input wire logic [7:0]  FETCH_DATA,
    input wire logic        ADDR_TRAP_RESET,
    input wire logic [4:0]  IRQ_PENDING,
    input wire logic        IRQ_ACCEPT_VALID,
    input wire logic [2:0]  IRQ_ACCEPT_ID
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    wire logic trap_op = EXEC_STROBE && EXEC_OPCODE == SOFT_TRAP_OPCODE;

    a_trap_raise:
        assert property (trap_op && !NMI_ACTIVE |=> SOFT_TRAP_IRQ)
        else $error("trap opcode gave no trap");
    a_trap_first:
        assert property (SOFT_TRAP_IRQ |-> IRQ_ACCEPT_VALID
            && IRQ_ACCEPT_ID == ID_SOFT_TRAP) else $error("trap not first");
    a_nmi_nop:
        assert property (trap_op && NMI_ACTIVE |=> EXEC_AS_NOP
            && !SOFT_TRAP_IRQ) else $error("trap during nmi");
    a_void_byte:
        assert property (FETCH_STROBE && SINGLE_CHIP
            && FETCH_ADDR inside {[16'h2000:16'hBFFF]}
            |=> FETCH_DATA == VOID_FETCH_BYTE) else $error("void fetch");
    a_fetch_trap:
        assert property (FETCH_STROBE && FETCH_ADDR inside
            {[16'h0000:16'h083F], [16'h1F80:16'h1FFF]} |=> ADDR_TRAP_RESET)
        else $error("no address trap");
    a_port_input:
        assert property (!PORT_BIT_DIR |-> !SHARED_PIN_OE)
        else $error("input port driven");
    a_mask_hold:
        assert property (!MASTER_IRQ_ENABLE && !SOFT_TRAP_IRQ
            |-> !IRQ_ACCEPT_VALID) else $error("accepted while masked");
    a_e_reject:
        assert property ($rose(EXT_IRQ_E) && $past(EXT_IRQ_E, 2)
            |=> (!$rose(IRQ_PENDING[4]))[*8]) else $error("noise latched");
    a_e_accept:
        assert property ($fell(EXT_IRQ_E) ##1 (!EXT_IRQ_E)[*5]
            |-> ##[1:6] IRQ_PENDING[4]) else $error("pulse not latched");

    cover property (SOFT_TRAP_IRQ);
    cover property (ADDR_TRAP_RESET);
    cover property (IRQ_ACCEPT_VALID && IRQ_ACCEPT_ID == 3'h1);
endmodule : ext_irq_props
`default_nettype wire

// ---- test/ext_pin_source.sv ----
// outside signal sources on the five interrupt pins
// assumes the caller steps it from its own clocked sequence
`timescale 1ns/100ps
`default_nettype none
module ext_pin_source
(
    input  wire logic       clk,
    output logic      [4:0] pins
);
    // lines idle high like pulled-up inputs
    initial pins = 5'h1F;

    // change one pin just after an edge, then hold it
    task automatic drive(input int idx, input logic val, input int hold);
        @(posedge clk);
        pins[idx] <= val;
        repeat (hold) @(posedge clk);
    endtask : drive
endmodule : ext_pin_source
`default_nettype wire

// ---- test/ext_irq_conditioning_bench.sv ----
// self-checking bench for the conditioning block
// assumes one 100 MHz clock and the pin source model
`timescale 1ns/100ps
`default_nettype none
module ext_irq_conditioning_bench
    import ext_irq_pkg::*;
;
    logic        mclk, rst_n, reg_wr, reg_rd, dir, master, nmi, exec;
    logic        single, fstb, p_data, pin_o, pin_oe, trap, nop, aerr;
    logic        trst, acc_v, port_in;
    logic [7:0]  reg_addr, reg_wdata, opcode, fdin, rdata_o, fdata;
    logic [15:0] faddr;
    logic [4:0]  pins, pend;
    logic [2:0]  acc_id;
    int          bad_count, checks_done;

    ext_pin_source i_src (.clk(mclk), .pins(pins));

    ext_irq_conditioning i_dut (.MCLK(mclk), .RST_N(rst_n),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(rdata_o),
        .EXT_IRQ_A(pin_oe ? pin_o : pins[0]), .EXT_IRQ_B(pins[1]),
        .EXT_IRQ_C(pins[2]), .EXT_IRQ_D(pins[3]), .EXT_IRQ_E(pins[4]),
        .PORT_BIT_DATA(p_data), .PORT_BIT_DIR(dir), .SHARED_PIN_O(pin_o),
        .SHARED_PIN_OE(pin_oe), .SHARED_PORT_BIT_IN(port_in),
        .MASTER_IRQ_ENABLE(master), .NMI_ACTIVE(nmi), .EXEC_STROBE(exec),
        .EXEC_OPCODE(opcode), .SOFT_TRAP_IRQ(trap), .EXEC_AS_NOP(nop),
        .ADDR_ERROR(aerr), .SINGLE_CHIP(single), .FETCH_STROBE(fstb),
        .FETCH_ADDR(faddr), .FETCH_DATA_IN(fdin), .FETCH_DATA(fdata),
        .ADDR_TRAP_RESET(trst), .IRQ_PENDING(pend),
        .IRQ_ACCEPT_VALID(acc_v), .IRQ_ACCEPT_ID(acc_id));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic summarize;
        if (bad_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask : rd

    task automatic clr;
        // latches written off whole, never read-modified
        wr(8'h41, 8'h1F);
    endtask : clr

    // watches a latch for a full window; a missed latch ends the run
    task automatic await(input int b, input int lim, input logic exp);
        logic hit;
        hit = 1'b0;
        repeat (lim)
        begin
            @(posedge mclk);
            #1 hit = hit | (pend[b] === 1'b1);
        end
        chk(hit, exp);
        if (exp && !hit)
            summarize();
    endtask : await

    task automatic run_op(input logic n);
        @(posedge mclk);
        exec   <= 1'b1;
        opcode <= SOFT_TRAP_OPCODE;
        nmi    <= n;
        @(posedge mclk);
        exec <= 1'b0;
        #1;
    endtask : run_op

    task automatic t_regs;
        rd(8'h37, 8'h00);
        rd(8'h40, 8'h00);
        rd(8'h10, 8'h00);
        // enables stay off while control is rewritten
        wr(8'h37, 8'hFF);
        rd(8'h37, CONTROL_RW_MASK);
        wr(8'h37, 8'h00);
    endtask : t_regs

    task automatic t_trap;
        logic [15:0] adr [7];
        adr = '{16'h0100, 16'h1F80, 16'h0037, 16'hC000, 16'h3000, 16'h1F70,
                16'h3000};
        run_op(1'b0);
        chk({trap, aerr, acc_id}, {1'b1, 1'b0, ID_SOFT_TRAP});
        run_op(1'b1);
        chk({trap, nop}, 2'b01);
        // the fifth fetch runs outside single-chip mode
        for (int i = 0; i < 7; i++)
        begin
            @(posedge mclk);
            fstb   <= 1'b1;
            faddr  <= adr[i];
            single <= i != 4;
            @(posedge mclk);
            fstb <= 1'b0;
            #1 chk(trst, i < 3);
            chk(fdata, i == 6 ? VOID_FETCH_BYTE : fdin);
        end
        run_op(1'b0);
        chk(aerr, 1'b1);
    endtask : t_trap

    task automatic t_ae;
        i_src.drive(0, 1'b0, 0);
        await(0, 15, 1'b0);
        chk(port_in, 1'b0);
        i_src.drive(0, 1'b1, 9);
        dir    <= 1'b1;
        p_data <= 1'b1;
        #1 chk({pin_oe, pin_o, port_in}, 3'b111);
        @(posedge mclk);
        // port back to input before the pin function changes
        dir <= 1'b0;
        wr(8'h37, 8'h40);
        for (int i = 0; i < 5; i += 4)
        begin
            i_src.drive(i, 1'b0, 0);
            i_src.drive(i, 1'b1, 0);
            await(i, 15, 1'b0);
            i_src.drive(i, 1'b0, 5);
            i_src.drive(i, 1'b1, 0);
            await(i, 20, 1'b1);
        end
        wr(8'h42, 8'h11);
        #1 chk(acc_v, 1'b0);
        @(posedge mclk);
        master <= 1'b1;
        #1 chk({acc_v, acc_id}, 8'h09);
        @(posedge mclk);
        master <= 1'b0;
        wr(8'h42, 8'h00);
        clr();
    endtask : t_ae

    task automatic t_bc;
        wr(8'h37, 8'h84);
        i_src.drive(1, 1'b0, 200);
        clr();
        i_src.drive(1, 1'b1, 13);
        i_src.drive(1, 1'b0, 0);
        await(1, 60, 1'b0);
        i_src.drive(1, 1'b1, 0);
        await(1, 49, 1'b1);
        wr(8'h37, 8'h04);
        i_src.drive(1, 1'b0, 200);
        clr();
        i_src.drive(1, 1'b1, 61);
        i_src.drive(1, 1'b0, 0);
        await(1, 200, 1'b0);
        i_src.drive(1, 1'b1, 0);
        await(1, 193, 1'b1);
        i_src.drive(2, 1'b0, 5);
        i_src.drive(2, 1'b1, 0);
        await(2, 40, 1'b0);
        i_src.drive(2, 1'b0, 0);
        await(2, 25, 1'b1);
        clr();
        i_src.drive(2, 1'b1, 0);
        await(2, 30, 1'b0);
        // opposite selects: B on its fall, C on its rise
        wr(8'h37, 8'h02);
        clr();
        i_src.drive(2, 1'b0, 0);
        await(2, 25, 1'b0);
        i_src.drive(2, 1'b1, 0);
        await(2, 25, 1'b1);
        i_src.drive(1, 1'b0, 0);
        await(1, 193, 1'b1);
    endtask : t_bc

    task automatic t_d;
        for (int m = 0; m < 3; m++)
        begin
            wr(8'h37, 8'(m << 4));
            i_src.drive(3, 1'b0, 40);
            clr();
            i_src.drive(3, 1'b1, 0);
            await(3, 25, m != 1);
            clr();
            i_src.drive(3, 1'b0, 0);
            await(3, 25, m != 0);
        end
        // pin held high across a second reset
        i_src.drive(3, 1'b1, 40);
        rst_n <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        wr(8'h37, 8'h30);
        await(3, 200, 1'b0);
        i_src.drive(3, 1'b0, 40);
        i_src.drive(3, 1'b1, 0);
        await(3, 25, 1'b1);
    endtask : t_d

    initial
    begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, dir, master, nmi, exec, fstb, p_data} = '0;
        {reg_addr, reg_wdata, opcode, faddr} = '0;
        single = 1'b1;
        fdin = 8'h5A;
        bad_count = 0;
        checks_done = 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        // filters need a full stable threshold after reset
        repeat (200) @(posedge mclk);
        t_regs();
        t_trap();
        t_ae();
        t_bc();
        t_d();
        summarize();
    end
endmodule : ext_irq_conditioning_bench

bind ext_irq_conditioning ext_irq_props i_props (.MCLK(MCLK),
    .RST_N(RST_N), .EXT_IRQ_E(EXT_IRQ_E), .PORT_BIT_DIR(PORT_BIT_DIR),
    .SHARED_PIN_OE(SHARED_PIN_OE), .MASTER_IRQ_ENABLE(MASTER_IRQ_ENABLE),
    .NMI_ACTIVE(NMI_ACTIVE), .EXEC_STROBE(EXEC_STROBE),
    .EXEC_OPCODE(EXEC_OPCODE), .SOFT_TRAP_IRQ(SOFT_TRAP_IRQ),
    .EXEC_AS_NOP(EXEC_AS_NOP), .SINGLE_CHIP(SINGLE_CHIP),
    .FETCH_STROBE(FETCH_STROBE), .FETCH_ADDR(FETCH_ADDR),
    .FETCH_DATA(FETCH_DATA), .ADDR_TRAP_RESET(ADDR_TRAP_RESET),
    .IRQ_PENDING(IRQ_PENDING), .IRQ_ACCEPT_VALID(IRQ_ACCEPT_VALID),
    .IRQ_ACCEPT_ID(IRQ_ACCEPT_ID));
`default_nettype wire
